// file: core/wwdc_top.sv
// Windowed watchdog control, counters and Wishbone register file.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1 - Period field in control 0 bits 5:1 picks ratio 1:32 doubling up to 1:8388608.
// R2 - Period codes 10011 to 11111 are reserved and give the shortest interval.
// R3 - Period field resets to 01011 if config period is 11111, else to config value.
// R4 - Period field ignores writes unless config period field is 11111.
// R5 - Software enable bit 0 resets low and only matters in mode 01.
// R6 - Clock select bits 6:4: 000 low oscillator, 001 medium, others reserved.
// R7 - Clock select resets to 000 if config clock is 111, else to config value, and is writable only when config clock is 111.
// R8 - Window select bits 2:0 open 12.5 percent per step, 111 fully open.
// R9 - Window select resets from config window field, writable only if that is 111.
// R10 - Timer bits 7:3 hold window counter; window opens at its selected threshold.
// R11 - Timer bit 2 shows whether the watchdog is armed.
// R12 - Eighteen-bit prescale count spans low, high and timer bits 1:0, reset zero.
// R13 - Timer register is read-only and reads zero after reset.
// R14 - Prescale low register is read-only with low count byte, reset zero.
// R15 - Windowed clear needs prior read of control 0, else it is a violation.
// R16 - Clear with window closed is a violation; violations reset like time-outs.
// R17 - Mode 11 always on, 10 on while awake, 01 software enable, 00 off.
// R18 - Any write to either control register clears the watchdog counters.
// R19 - Prescaler advances per watchdog tick; reaching the ratio while active times out.
module wwdc_top
(
  // Clock, reset and clock enable.
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  // Wishbone slave.
  input  wire wwdc_pkg::wwdc_wb_req_s wb_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  // Configuration, oscillators and core events.
  input  wire wwdc_pkg::wwdc_cfg_s   cfg_i,
  input  wire logic                  low_freq_oscillator_i,
  input  wire logic                  medium_freq_oscillator_i,
  input  wire logic                  sleep_i,
  input  wire logic                  clear_request_i,
  // Watchdog reset pulse and interrupt level.
  output logic                       wdt_reset_o,
  output logic                       irq_o
);

  import wwdc_pkg::*;

  // Mask of prescaler bits used by a period code.
  function automatic logic [17:0] psc_mask(input logic [4:0] ps);
    psc_mask = (18'h00001 << ps) - 18'h00001;
  endfunction

  // Window counter value from which the window is open.
  function automatic logic [4:0] win_threshold(input logic [2:0] win);
    win_threshold = {~win, 2'b00};
  endfunction

  wwdc_bus_e   bus_q;
  wwdc_bus_e   bus_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic        reset_q;
  logic        reset_d;
  logic        irq_q;
  logic        irq_d;
  logic [4:0]  ps_q;
  logic [4:0]  ps_d;
  logic        sen_q;
  logic        sen_d;
  logic [2:0]  cs_q;
  logic [2:0]  cs_d;
  logic [2:0]  win_q;
  logic [2:0]  win_d;
  logic [17:0] psc_q;
  logic [17:0] psc_d;
  logic [4:0]  wcnt_q;
  logic [4:0]  wcnt_d;
  logic        armed_q;
  logic        armed_d;
  logic        sleep_q;
  logic        sleep_d;
  logic [1:0]  stat_q;
  logic [1:0]  stat_d;
  logic [1:0]  mask_q;
  logic [1:0]  mask_d;

  logic        tick;
  logic        active;
  logic        windowed;
  logic        win_open;
  logic [4:0]  ps_eff;
  logic        psc_last;
  logic [13:0] idx;
  logic        acc;
  logic        wr;
  logic        rd_c0;
  logic        ctrl_wr;
  logic        clr_evt;
  logic        viol;
  logic        valid_clr;
  logic        timeout;
  logic        zero;

  // Watchdog clock source.
  wwdc_tick_sel u_tick
  (
    .clk_i                    (clk_i),
    .rst_i                    (rst_i),
    .ce_i                     (ce_i),
    .clk_sel_i                (cs_q),  // R6
    .low_freq_oscillator_i    (low_freq_oscillator_i),
    .medium_freq_oscillator_i (medium_freq_oscillator_i),
    .tick_o                   (tick)
  );

  // Decode of the bus access, mode and window state.
  always_comb
  begin
    idx      = wb_i.adr[15:2];
    acc      = (bus_q == WWDC_BUS_ACK) && wb_i.cyc && wb_i.stb;
    wr       = acc && wb_i.we && wb_i.sel[0];
    rd_c0    = acc && !wb_i.we && (idx == WWDC_IDX_CTRL0);  // R15
    ctrl_wr  = wr && ((idx == WWDC_IDX_CTRL0) || (idx == WWDC_IDX_CTRL1));  // R18
    case (cfg_i.config_mode_field)  // R17
      WWDC_MODE_ON:    active = 1'b1;
      WWDC_MODE_AWAKE: active = !sleep_i;
      WWDC_MODE_SW:    active = sen_q;  // R5
      default:         active = 1'b0;
    endcase
    ps_eff   = (ps_q > WWDC_PS_MAX_CODE) ? WWDC_PS_MIN_CODE : ps_q;  // R2
    psc_last = (psc_q == psc_mask(ps_eff));  // R1
    windowed = (win_q != WWDC_WIN_ALWAYS);
    win_open = !windowed || (wcnt_q >= win_threshold(win_q));  // R8 R10
    clr_evt  = clear_request_i && active;
    viol     = clr_evt && windowed && (!armed_q || !win_open);  // R15 R16
    valid_clr = clr_evt && !viol;
    timeout  = active && tick && psc_last && (wcnt_q == WWDC_WCNT_LAST)
               && !valid_clr && !ctrl_wr;  // R19
    zero     = !active || valid_clr || viol || ctrl_wr || timeout || (sleep_i && !sleep_q);
  end

  // Next state of bus slave, control registers, counters and events.
  always_comb
  begin
    bus_d   = bus_q;
    dat_d   = dat_q;
    ps_d    = ps_q;
    sen_d   = sen_q;
    cs_d    = cs_q;
    win_d   = win_q;
    mask_d  = mask_q;
    psc_d   = psc_q;
    wcnt_d  = wcnt_q;
    armed_d = armed_q;
    sleep_d = sleep_i;
    reset_d = viol || timeout;  // R16 R19
    stat_d  = stat_q;
    case (bus_q)
      WWDC_BUS_IDLE:
      begin
        if (wb_i.cyc && wb_i.stb)
        begin
          bus_d = WWDC_BUS_ACK;
          dat_d = WWDC_DAT_ZERO;
          case (idx)
            WWDC_IDX_CTRL0: dat_d[7:0] = {2'b00, ps_q, sen_q};
            WWDC_IDX_CTRL1: dat_d[7:0] = {1'b0, cs_q, 1'b0, win_q};
            WWDC_IDX_PSL:   dat_d[7:0] = psc_q[7:0];  // R14 R12
            WWDC_IDX_PSH:   dat_d[7:0] = psc_q[15:8];  // R12
            WWDC_IDX_TMR:   dat_d[7:0] = {wcnt_q, armed_q, psc_q[17:16]};  // R10 R11 R12
            WWDC_IDX_STAT:  dat_d[1:0] = stat_q;
            WWDC_IDX_MASK:  dat_d[1:0] = mask_q;
            default:        dat_d = WWDC_DAT_ZERO;
          endcase
        end
      end
      WWDC_BUS_ACK:
      begin
        bus_d = WWDC_BUS_IDLE;
        dat_d = WWDC_DAT_ZERO;
      end
      default:
      begin
        bus_d = WWDC_BUS_IDLE;
      end
    endcase
    // Writes land at the edge where the master sees acknowledge; the timer is not writable.
    if (wr && (idx == WWDC_IDX_CTRL0))
    begin
      sen_d = wb_i.dat[WWDC_SEN_BIT];  // R5
      if (cfg_i.config_period_field == WWDC_PS_UNLOCKED)  // R4
        ps_d = wb_i.dat[WWDC_PS_LSB +: 5];
    end
    if (wr && (idx == WWDC_IDX_CTRL1))
    begin
      if (cfg_i.config_clock_field == WWDC_CS_UNLOCKED)  // R7
        cs_d = wb_i.dat[WWDC_CS_LSB +: 3];
      if (cfg_i.config_window_field == WWDC_WIN_UNLOCKED)  // R9
        win_d = wb_i.dat[WWDC_WIN_LSB +: 3];
    end
    if (wr && (idx == WWDC_IDX_MASK))
      mask_d = wb_i.dat[1:0];
    // Counters restart on any clear, otherwise advance once per watchdog tick.
    if (zero)
    begin
      psc_d  = WWDC_PSC_RESET;  // R18
      wcnt_d = WWDC_WCNT_RESET;
    end
    else if (tick)
    begin
      if (psc_last)
      begin
        psc_d  = WWDC_PSC_RESET;
        wcnt_d = wcnt_q + 5'h01;  // R19
      end
      else
      begin
        psc_d = psc_q + 18'h00001;
      end
    end
    // Arming by a control 0 read; cleared by any clear attempt or while disabled.
    if (valid_clr || viol || !active)
      armed_d = 1'b0;
    else if (rd_c0)
      armed_d = 1'b1;  // R15
    // Sticky events: write one to clear, a new event wins over the clear.
    if (wr && (idx == WWDC_IDX_STAT))
      stat_d = stat_q & ~wb_i.dat[1:0];
    if (timeout)
      stat_d[WWDC_ST_TIMEOUT] = 1'b1;
    if (viol)
      stat_d[WWDC_ST_VIOL] = 1'b1;
    irq_d = |(stat_d & mask_d);
  end

  // State registers; reset loads the configuration-dependent values.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_q   <= WWDC_BUS_IDLE;
      dat_q   <= WWDC_DAT_ZERO;
      reset_q <= 1'b0;
      irq_q   <= 1'b0;
      ps_q    <= (cfg_i.config_period_field == WWDC_PS_UNLOCKED) ?
                 WWDC_PS_DEFAULT : cfg_i.config_period_field;  // R3
      sen_q   <= 1'b0;  // R5
      cs_q    <= (cfg_i.config_clock_field == WWDC_CS_UNLOCKED) ?
                 WWDC_CS_DEFAULT : cfg_i.config_clock_field;  // R7
      win_q   <= cfg_i.config_window_field;  // R9
      psc_q   <= WWDC_PSC_RESET;  // R12 R13
      wcnt_q  <= WWDC_WCNT_RESET;  // R13
      armed_q <= 1'b0;
      sleep_q <= 1'b0;
      stat_q  <= WWDC_IRQ_RESET;
      mask_q  <= WWDC_IRQ_RESET;
    end
    else if (ce_i)
    begin
      bus_q   <= bus_d;
      dat_q   <= dat_d;
      reset_q <= reset_d;
      irq_q   <= irq_d;
      ps_q    <= ps_d;
      sen_q   <= sen_d;
      cs_q    <= cs_d;
      win_q   <= win_d;
      psc_q   <= psc_d;
      wcnt_q  <= wcnt_d;
      armed_q <= armed_d;
      sleep_q <= sleep_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
    end
  end

  assign wb_ack_o    = (bus_q == WWDC_BUS_ACK);
  assign wb_dat_o    = dat_q;
  assign wdt_reset_o = reset_q;
  assign irq_o       = irq_q;

  // Full count while active must end in a reset pulse.
  timeout_pulse_a : assert property (@(posedge clk_i) disable iff (rst_i)  // R19
    ce_i && active && tick && psc_last && wcnt_q == 5'h1F && !clr_evt && !ctrl_wr
    |=> wdt_reset_o)
    else $error("time-out did not pulse reset");

  // A reserved period code must count like the shortest ratio.
  reserved_period_a : assert property (@(posedge clk_i) disable iff (rst_i)  // R2
    (ps_q > 5'h12) |-> (psc_mask(ps_eff) == 18'h00000))
    else $error("reserved period not at minimum");

  // A locked period field never moves outside reset.
  period_lock_a : assert property (@(posedge clk_i) disable iff (rst_i)  // R4
    (cfg_i.config_period_field != 5'h1F) |=> $stable(ps_q))
    else $error("locked period field changed");

  // A locked clock select never moves outside reset.
  clock_lock_a : assert property (@(posedge clk_i) disable iff (rst_i)  // R7
    (cfg_i.config_clock_field != 3'h7) |=> $stable(cs_q))
    else $error("locked clock select changed");

  // With the full window any clear is accepted, armed or not.
  full_window_a : assert property (@(posedge clk_i) disable iff (rst_i)  // R10
    ce_i && clear_request_i && active && win_q == 3'h7
    |=> !wdt_reset_o && psc_q == 18'h00000 && wcnt_q == 5'h00)
    else $error("clear in full window was not accepted");

  // A control 0 read arms, and the arming holds until something clears it.
  arm_on_read_a : assert property (@(posedge clk_i) disable iff (rst_i)  // R15 R11
    ce_i && rd_c0 && active && !clear_request_i |=> armed_q ##1 (armed_q || $past(zero)))
    else $error("control read did not arm");

  // An unarmed clear in windowed mode gives a one-cycle reset pulse.
  unarmed_viol_a : assert property (@(posedge clk_i) disable iff (rst_i)  // R15 R16
    ce_i && clear_request_i && active && win_q != 3'h7 && !armed_q
    |=> wdt_reset_o ##1 !wdt_reset_o || $past(viol || timeout))
    else $error("unarmed clear did not violate");

  // A control register write restarts both counters.
  ctrl_write_clear_a : assert property (@(posedge clk_i) disable iff (rst_i)  // R18
    ce_i && ctrl_wr |=> psc_q == 18'h00000 && wcnt_q == 5'h00)
    else $error("control write did not clear counters");

  // The disabled mode neither counts nor resets.
  mode_off_a : assert property (@(posedge clk_i) disable iff (rst_i)  // R17
    ce_i && cfg_i.config_mode_field == 2'b00 |=> psc_q == 18'h00000 && !wdt_reset_o)
    else $error("disabled watchdog counted");

  // An unmasked violation sets its status bit and raises the interrupt.
  irq_level_a : assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && viol && mask_d[WWDC_ST_VIOL] |=> irq_o && stat_q[WWDC_ST_VIOL])
    else $error("violation did not raise interrupt");

  // An armed clear while the window is still closed must reset.
  closed_window_a : assert property (@(posedge clk_i) disable iff (rst_i)  // R16
    ce_i && clear_request_i && active && windowed && armed_q && !win_open |=> wdt_reset_o)
    else $error("clear in closed window did not violate");

  // Every clear attempt leaves the watchdog disarmed.
  clear_disarm_a : assert property (@(posedge clk_i) disable iff (rst_i)  // R15
    ce_i && clr_evt |=> !armed_q)
    else $error("clear left the watchdog armed");

  // A time-out leaves its sticky status bit set.
  timeout_status_a : assert property (@(posedge clk_i) disable iff (rst_i)  // R19
    ce_i && timeout |=> stat_q[WWDC_ST_TIMEOUT])
    else $error("time-out status not set");

endmodule
`default_nettype wire

// file: inc/wwdc_pkg.sv
// Package with register map, field layout and shared types of the windowed watchdog.
package wwdc_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [13:0] WWDC_IDX_CTRL0  = 14'h0ECD;
  localparam logic [13:0] WWDC_IDX_CTRL1  = 14'h0ECE;
  localparam logic [13:0] WWDC_IDX_PSL    = 14'h0ECF;
  localparam logic [13:0] WWDC_IDX_PSH    = 14'h0ED0;
  localparam logic [13:0] WWDC_IDX_TMR    = 14'h0ED1;
  localparam logic [13:0] WWDC_IDX_STAT   = 14'h0ED2;
  localparam logic [13:0] WWDC_IDX_MASK   = 14'h0ED3;

  // Field positions inside the control and timer registers.
  localparam int WWDC_SEN_BIT    = 0;
  localparam int WWDC_PS_LSB     = 1;
  localparam int WWDC_WIN_LSB    = 0;
  localparam int WWDC_CS_LSB     = 4;
  localparam int WWDC_ARMED_BIT  = 2;
  localparam int WWDC_WCNT_LSB   = 3;

  // Status and mask bit positions.
  localparam int WWDC_ST_TIMEOUT = 0;
  localparam int WWDC_ST_VIOL    = 1;

  // Reset values and special codes.
  localparam logic [4:0]  WWDC_PS_UNLOCKED  = 5'h1F;
  localparam logic [4:0]  WWDC_PS_DEFAULT   = 5'h0B;
  localparam logic [4:0]  WWDC_PS_MAX_CODE  = 5'h12;
  localparam logic [4:0]  WWDC_PS_MIN_CODE  = 5'h00;
  localparam logic [2:0]  WWDC_CS_UNLOCKED  = 3'h7;
  localparam logic [2:0]  WWDC_CS_DEFAULT   = 3'h0;
  localparam logic [2:0]  WWDC_CS_LOW_OSC   = 3'h0;
  localparam logic [2:0]  WWDC_CS_MED_OSC   = 3'h1;
  localparam logic [2:0]  WWDC_WIN_UNLOCKED = 3'h7;
  localparam logic [2:0]  WWDC_WIN_ALWAYS   = 3'h7;
  localparam logic [4:0]  WWDC_WCNT_LAST    = 5'h1F;
  localparam logic [17:0] WWDC_PSC_RESET    = 18'h00000;
  localparam logic [4:0]  WWDC_WCNT_RESET   = 5'h00;
  localparam logic [1:0]  WWDC_IRQ_RESET    = 2'h0;
  localparam logic [31:0] WWDC_DAT_ZERO     = 32'h00000000;

  // Operating mode codes of the configuration mode field.
  localparam logic [1:0] WWDC_MODE_ON     = 2'h3;
  localparam logic [1:0] WWDC_MODE_AWAKE  = 2'h2;
  localparam logic [1:0] WWDC_MODE_SW     = 2'h1;
  localparam logic [1:0] WWDC_MODE_OFF    = 2'h0;

  // Non-volatile configuration fields seen by the watchdog.
  typedef struct packed {
    logic [1:0] config_mode_field;
    logic [4:0] config_period_field;
    logic [2:0] config_clock_field;
    logic [2:0] config_window_field;
  } wwdc_cfg_s;

  // Classic Wishbone request from the master.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wwdc_wb_req_s;

  // Bus slave states.
  typedef enum logic [0:0] {WWDC_BUS_IDLE, WWDC_BUS_ACK} wwdc_bus_e;

endpackage

// file: core/wwdc_tick_sel.sv
// Watchdog clock source selection and edge detection into one-cycle ticks.
`timescale 1ns/1ns
`default_nettype none
module wwdc_tick_sel
(
  // Clock, reset and enable.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Source selection and oscillator levels.
  input  wire logic [2:0] clk_sel_i,
  input  wire logic       low_freq_oscillator_i,
  input  wire logic       medium_freq_oscillator_i,
  // One-cycle pulse per rising edge of the chosen oscillator.
  output logic            tick_o
);

  import wwdc_pkg::*;

  logic src_c;
  logic prev_q;
  logic prev_d;

  // Pick the oscillator; reserved codes select no source so the timer stalls.
  always_comb
  begin
    src_c  = 1'b0;
    prev_d = prev_q;
    case (clk_sel_i)
      WWDC_CS_LOW_OSC: src_c = low_freq_oscillator_i;
      WWDC_CS_MED_OSC: src_c = medium_freq_oscillator_i;
      default:         src_c = 1'b0;
    endcase
    prev_d = src_c;
  end

  // Remember the previous level to find rising edges.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_q <= 1'b0;
    else if (ce_i)
      prev_q <= prev_d;
  end

  assign tick_o = src_c & ~prev_q & ce_i;

endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking testbench for the windowed watchdog control block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import wwdc_pkg::*;

  // Bench stimulus, observed outputs and counters.
  logic         clk;
  logic         rst;
  wwdc_wb_req_s wb;
  wwdc_cfg_s    cfg;
  logic         low_osc;
  logic         med_osc;
  logic         sleep;
  logic         clr;
  logic [31:0]  rdat;
  logic         ack;
  logic         wdt_rst;
  logic         irq;
  int           error_cnt;
  int           check_count;
  int           rst_seen;
  int           rst_base;
  logic [7:0]   d;

  // Device under test; only the clock enable is tied.
  wwdc_top u_dut (
    .clk_i                    (clk),
    .rst_i                    (rst),
    .ce_i                     (1'b1),
    .wb_i                     (wb),
    .wb_dat_o                 (rdat),
    .wb_ack_o                 (ack),
    .cfg_i                    (cfg),
    .low_freq_oscillator_i    (low_osc),
    .medium_freq_oscillator_i (med_osc),
    .sleep_i                  (sleep),
    .clear_request_i          (clr),
    .wdt_reset_o              (wdt_rst),
    .irq_o                    (irq)
  );

  // Free-running 10 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Counts watchdog reset pulses, one per high cycle.
  always @(posedge clk)
  begin
    if (wdt_rst === 1'b1)
      rst_seen++;
  end

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Compares one byte and counts the outcome.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle, held until the acknowledge is sampled.
  task automatic wb_cyc(input logic we, input logic [13:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
    @(posedge clk);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'hF,
            dat: {24'h000000, wd}};
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    rd = rdat[7:0];
    wb <= '0;
  endtask

  // Register write.
  task automatic wr(input logic [13:0] idx, input logic [7:0] v);
    logic [7:0] unused;
    wb_cyc(1'b1, idx, v, unused);
  endtask

  // Register read compared against an expected byte.
  task automatic rd_chk(input logic [13:0] idx, input logic [7:0] exp);
    logic [7:0] got;
    wb_cyc(1'b0, idx, 8'h00, got);
    chk(got, exp);
  endtask

  // Rising edges of one oscillator, then time for the tick to land.
  task automatic tick(input logic med, input int n);
    repeat (n)
    begin
      @(posedge clk);
      if (med)
        med_osc <= 1'b1;
      else
        low_osc <= 1'b1;
      @(posedge clk);
      med_osc <= 1'b0;
      low_osc <= 1'b0;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask

  // One clear request pulse.
  task automatic clear_req;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Checks the number of watchdog resets since the last mark.
  task automatic rst_chk(input int exp);
    chk(8'(rst_seen - rst_base), 8'(exp));
    rst_base = rst_seen;
  endtask

  // Checks the interrupt level once it has settled.
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, {7'h00, exp});
  endtask

  // Applies a configuration and a five-cycle reset.
  task automatic do_reset(input logic [1:0] m, input logic [4:0] p, input logic [2:0] c,
                          input logic [2:0] w);
    @(posedge clk);
    cfg <= '{config_mode_field: m, config_period_field: p, config_clock_field: c,
             config_window_field: w};
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
  endtask

  // Hang guard, sized well above the expected run of a few hundred cycles.
  initial
  begin
    #3000000;
    error_cnt++;
    $display("MISMATCH at %0t: run did not finish", $time);
    complete_run();
  end

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    wb = '0;
    cfg = '0;
    low_osc = 1'b0;
    med_osc = 1'b0;
    sleep = 1'b0;
    clr = 1'b0;
    error_cnt = 0;
    check_count = 0;
    rst_seen = 0;
    rst_base = 0;
    // Every mode asleep with the enable low: only the always-on mode counts.
    for (int m = 0; m < 4; m++)
    begin
      do_reset(2'(m), 5'h1F, 3'h7, 3'h7);
      sleep <= 1'b1;
      wr(WWDC_IDX_CTRL0, 8'h00);
      tick(1'b0, 3);
      rd_chk(WWDC_IDX_TMR, (m == 3) ? 8'h18 : 8'h00);
      sleep <= 1'b0;
    end
    // Awake mode counts while awake; sleep entry clears and stops it.
    do_reset(WWDC_MODE_AWAKE, 5'h1F, 3'h7, 3'h7);
    wr(WWDC_IDX_CTRL0, 8'h00);
    tick(1'b0, 2);
    rd_chk(WWDC_IDX_TMR, 8'h10);
    sleep <= 1'b1;
    rd_chk(WWDC_IDX_TMR, 8'h00);
    sleep <= 1'b0;
    // Unlocked configuration, software mode.
    do_reset(WWDC_MODE_SW, 5'h1F, 3'h7, 3'h7);
    rd_chk(WWDC_IDX_CTRL0, 8'h16);
    rd_chk(WWDC_IDX_CTRL1, 8'h07);
    rd_chk(WWDC_IDX_PSL, 8'h00);
    rd_chk(WWDC_IDX_PSH, 8'h00);
    wr(WWDC_IDX_TMR, 8'hFF);
    rd_chk(WWDC_IDX_TMR, 8'h00);
    rd_chk(14'h0100, 8'h00);
    tick(1'b0, 3);
    rd_chk(WWDC_IDX_TMR, 8'h00);
    // Period code 1: two ticks per window step.
    wr(WWDC_IDX_CTRL0, 8'h03);
    tick(1'b0, 5);
    rd_chk(WWDC_IDX_PSL, 8'h01);
    rd_chk(WWDC_IDX_TMR, 8'h10);
    wr(WWDC_IDX_CTRL1, 8'h07);
    rd_chk(WWDC_IDX_TMR, 8'h00);
    // Reserved period behaves as the shortest one: 32 ticks to time-out.
    wr(WWDC_IDX_CTRL0, 8'h27);
    rst_base = rst_seen;
    tick(1'b0, 31);
    rd_chk(WWDC_IDX_TMR, 8'hF8);
    rst_chk(0);
    tick(1'b0, 1);
    rst_chk(1);
    rd_chk(WWDC_IDX_TMR, 8'h00);
    rd_chk(WWDC_IDX_STAT, 8'h01);
    // Interrupt follows status and mask.
    irq_chk(1'b0);
    wr(WWDC_IDX_MASK, 8'h01);
    irq_chk(1'b1);
    wr(WWDC_IDX_MASK, 8'h00);
    irq_chk(1'b0);
    wr(WWDC_IDX_MASK, 8'h01);
    wr(WWDC_IDX_STAT, 8'h01);
    irq_chk(1'b0);
    rd_chk(WWDC_IDX_STAT, 8'h00);
    // Full window: an unarmed clear is accepted without reset.
    tick(1'b0, 2);
    clear_req();
    rst_chk(0);
    rd_chk(WWDC_IDX_TMR, 8'h00);
    // Smallest window: clears without arming or while closed are violations.
    wr(WWDC_IDX_CTRL1, 8'h00);
    wr(WWDC_IDX_MASK, 8'h02);
    clear_req();
    rst_chk(1);
    irq_chk(1'b1);
    rd_chk(WWDC_IDX_STAT, 8'h02);
    wr(WWDC_IDX_STAT, 8'h02);
    irq_chk(1'b0);
    rd_chk(WWDC_IDX_CTRL0, 8'h27);
    rd_chk(WWDC_IDX_TMR, 8'h04);
    tick(1'b0, 3);
    clear_req();
    rst_chk(1);
    rd_chk(WWDC_IDX_TMR, 8'h00);
    rd_chk(WWDC_IDX_CTRL0, 8'h27);
    tick(1'b0, 28);
    rd_chk(WWDC_IDX_TMR, 8'hE4);
    clear_req();
    rst_chk(0);
    rd_chk(WWDC_IDX_TMR, 8'h00);
    // Locked configuration, always on, medium oscillator.
    do_reset(WWDC_MODE_ON, 5'h05, 3'h1, 3'h3);
    rd_chk(WWDC_IDX_CTRL1, 8'h13);
    wr(WWDC_IDX_CTRL0, 8'h3F);
    wr(WWDC_IDX_CTRL1, 8'h77);
    rd_chk(WWDC_IDX_CTRL0, 8'h0B);
    rd_chk(WWDC_IDX_CTRL1, 8'h13);
    tick(1'b0, 3);
    rd_chk(WWDC_IDX_PSL, 8'h00);
    tick(1'b1, 3);
    rd_chk(WWDC_IDX_PSL, 8'h03);
    complete_run();
  end

endmodule
`default_nettype wire
